// >>> test/tb_bridge_cfg_header_0c_to_1c.sv
`timescale 1ns/1ns

// ------------------------------------------------------------
// compare helper
// ------------------------------------------------------------
`define CHK(got, exp, msg) \
    begin \
        checked = checked + 1; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch = n_mismatch + 1; \
            $display("unexpected at %0t: %s", $time, msg); \
        end \
    end

module tb_bridge_cfg_header_0c_to_1c;
    import bridge_cfg_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic                  clk_sys;
    logic                  srst;
    logic                  strap_reverse;
    logic                  strap_pcix;
    logic [ADDR_W-1:0]     reg_addr;
    logic [DATA_W-1:0]     reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [DATA_W-1:0]     reg_rdata;
    bus_numbers_type       bus_numbers;
    io_window_type         io_window;
    logic [BYTE_W-1:0]     primary_timer;
    logic [BYTE_W-1:0]     secondary_timer;
    logic                  reverse_mode;
    logic                  pcix_mode;
    int                    n_mismatch = 0;
    int                    checked = 0;

    bridge_cfg_header_0c_to_1c u_bridge_cfg_header_0c_to_1c (
        .clk_sys         (clk_sys),
        .srst            (srst),
        .strap_reverse   (strap_reverse),
        .strap_pcix      (strap_pcix),
        .reg_addr        (reg_addr),
        .reg_wdata       (reg_wdata),
        .reg_wr          (reg_wr),
        .reg_rd          (reg_rd),
        .reg_rdata       (reg_rdata),
        .bus_numbers     (bus_numbers),
        .io_window       (io_window),
        .primary_timer   (primary_timer),
        .secondary_timer (secondary_timer),
        .reverse_mode    (reverse_mode),
        .pcix_mode       (pcix_mode)
    );

    // ------------------------------------------------------------
    // clock and time-zero values
    // ------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial
    begin
        srst          = 1'b1;
        strap_reverse = 1'b0;
        strap_pcix    = 1'b0;
        reg_addr      = 8'h00;
        reg_wdata     = 32'h0000_0000;
        reg_wr        = 1'b0;
        reg_rd        = 1'b0;
    end

    // ------------------------------------------------------------
    // expected dwords
    // ------------------------------------------------------------
    function automatic logic [DATA_W-1:0] exp_hdr(input logic rev, input logic [7:0] pt);
        exp_hdr = {8'h00, 1'b0, LAYOUT_BRIDGE, rev ? pt : 8'h00, 8'h00};
    endfunction : exp_hdr

    function automatic logic [DATA_W-1:0] exp_io(input logic rev, input logic pcix,
                                                input logic [3:0] lim, input logic [3:0] base);
        exp_io = {8'h00, ~rev & ~pcix, 1'b0, ~rev, 5'h00,
                  lim, 2'h0, IO_ADDR_32, base, 2'h0, IO_ADDR_32};
    endfunction : exp_io

    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    task automatic do_reset(input logic rev, input logic pcix);
        @(posedge clk_sys);
        srst          <= 1'b1;
        strap_reverse <= rev;
        strap_pcix    <= pcix;
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        #1;
    endtask : do_reset

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stands one cycle only, zero after
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, exp, msg)
        @(posedge clk_sys);
        #1;
        `CHK(reg_rdata, 32'h0000_0000, "read data not cleared")
    endtask : rd

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values(input logic rev, input logic pcix);
        logic [7:0] tr;
        tr = pcix ? 8'h40 : 8'h00;
        do_reset(rev, pcix);
        `CHK(primary_timer, rev ? tr : 8'h00, "primary timer reset")
        `CHK(secondary_timer, rev ? 8'h00 : tr, "secondary timer reset")
        `CHK(bus_numbers, 24'h000000, "bus numbers reset")
        `CHK(io_window, 8'h00, "io window reset")
        `CHK({reverse_mode, pcix_mode}, {rev, pcix}, "straps latched")
        rd(OFF_HDR, exp_hdr(rev, tr), "header dword reset");
        rd(OFF_RSV0, 32'h0000_0000, "reserved 10h");
        rd(OFF_RSV1, 32'h0000_0000, "reserved 14h");
        rd(OFF_BUS, {rev ? 8'h00 : tr, 24'h000000}, "bus dword reset");
        rd(OFF_IO, exp_io(rev, pcix, 4'h0, 4'h0), "io dword reset");
        rd(8'hFC, 32'h0000_0000, "unmapped read");
        $display("test reset values rev=%0b pcix=%0b done", rev, pcix);
    endtask : t_reset_values

    task automatic t_fixed_writes(input logic rev, input logic pcix);
        logic [7:0] a [6];
        a = '{OFF_HDR, OFF_RSV0, OFF_RSV1, OFF_BUS, OFF_IO, 8'h20};
        foreach (a[i])
            wr(a[i], 32'hFFFF_FFFF);
        rd(OFF_HDR, exp_hdr(rev, 8'hFF), "header after ones");
        rd(OFF_RSV0, 32'h0000_0000, "reserved 10h written");
        rd(OFF_RSV1, 32'h0000_0000, "reserved 14h written");
        rd(8'h20, 32'h0000_0000, "unmapped written");
        rd(OFF_BUS, {rev ? 8'h00 : 8'hFF, 24'hFFFFFF}, "bus after ones");
        rd(OFF_IO, exp_io(rev, pcix, 4'hF, 4'hF), "io after ones");
        `CHK(primary_timer, rev ? 8'hFF : 8'h00, "primary timer output")
        `CHK(secondary_timer, rev ? 8'h00 : 8'hFF, "secondary timer output")
        `CHK(bus_numbers, 24'hFFFFFF, "bus numbers output")
        `CHK(io_window, 8'hFF, "io window output")
        $display("test fixed writes rev=%0b pcix=%0b done", rev, pcix);
    endtask : t_fixed_writes

    task automatic t_walk(input logic rev, input logic pcix);
        do_reset(rev, pcix);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= OFF_BUS;
        reg_wdata <= 32'h4433_2211;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, {rev ? 8'h00 : 8'h44, 24'h332211}, "write then read")
        `CHK(bus_numbers.highest, 8'h33, "highest bus number")
        `CHK(bus_numbers.upstream, 8'h11, "upstream bus number")
        wr(OFF_IO, 32'h0000_7040);
        rd(OFF_IO, exp_io(rev, pcix, 4'h7, 4'h4), "io nibbles");
        wr(OFF_HDR, 32'h1234_5600);
        rd(OFF_HDR, exp_hdr(rev, 8'h56), "primary timer write");
        $display("test back to back rev=%0b pcix=%0b done", rev, pcix);
    endtask : t_walk

    // straps move only through reset
    task automatic t_strap_hold();
        do_reset(1'b0, 1'b1);
        @(posedge clk_sys);
        strap_reverse <= 1'b1;
        strap_pcix    <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        `CHK({reverse_mode, pcix_mode}, 2'b01, "straps moved outside reset")
        rd(OFF_IO, exp_io(1'b0, 1'b1, 4'h0, 4'h0), "status after strap move");
        $display("test strap hold done");
    endtask : t_strap_hold

    // ------------------------------------------------------------
    // verdict
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    initial
    begin
        for (int m = 0; m < 4; m++)
        begin
            t_reset_values(m[1], m[0]);
            t_fixed_writes(m[1], m[0]);
            t_walk(m[1], m[0]);
        end
        t_strap_hold();
        wrap_up();
    end

    // whole run is well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: watchdog expired", $time);
        wrap_up();
    end

endmodule : tb_bridge_cfg_header_0c_to_1c

// >>> verilog/bridge_cfg_header_0c_to_1c.sv
`timescale 1ns/1ns

module bridge_cfg_header_0c_to_1c (
    // clock and reset
    input  wire logic                             clk_sys,
    input  wire logic                             srst,
    // mode straps, caught while reset is high
    input  wire logic                             strap_reverse,
    input  wire logic                             strap_pcix,
    // register port
    input  wire logic [bridge_cfg_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [bridge_cfg_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                             reg_wr,
    input  wire logic                             reg_rd,
    output logic      [bridge_cfg_pkg::DATA_W-1:0] reg_rdata,
    // settings for forwarding logic
    output bridge_cfg_pkg::bus_numbers_type        bus_numbers,
    output bridge_cfg_pkg::io_window_type          io_window,
    output logic      [bridge_cfg_pkg::BYTE_W-1:0] primary_timer,
    output logic      [bridge_cfg_pkg::BYTE_W-1:0] secondary_timer,
    output logic                                  reverse_mode,
    output logic                                  pcix_mode
);
    import bridge_cfg_pkg::*;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire logic hit_hdr;
    wire logic hit_bus;
    wire logic hit_io;
    wire logic wr_hdr;
    wire logic wr_bus;
    wire logic wr_io;

    assign hit_hdr = (reg_addr == OFF_HDR);
    assign hit_bus = (reg_addr == OFF_BUS);
    assign hit_io  = (reg_addr == OFF_IO);
    assign wr_hdr  = reg_wr && hit_hdr && !srst;
    assign wr_bus  = reg_wr && hit_bus && !srst;
    assign wr_io   = reg_wr && hit_io && !srst;

    // ------------------------------------------------------------
    // write enables per field
    // ------------------------------------------------------------
    wire logic pri_timer_we;
    wire logic sec_timer_we;
    wire logic [BYTE_W-1:0] timer_reset_value;

    assign pri_timer_we = wr_hdr && reverse_mode;
    assign sec_timer_we = wr_bus && !reverse_mode;
    // reset value follows the strap seen at reset
    assign timer_reset_value = strap_pcix ? TIMER_RST_PCIX : TIMER_RST_PCI;

    // ------------------------------------------------------------
    // mode straps
    // ------------------------------------------------------------
    // straps are only trusted while reset is held
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            reverse_mode <= strap_reverse;
            pcix_mode    <= strap_pcix;
        end
    end

    // ------------------------------------------------------------
    // latency timers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            // only the writable timer takes the mode value
            primary_timer   <= strap_reverse ? timer_reset_value : TIMER_RST_PCI;
            secondary_timer <= strap_reverse ? TIMER_RST_PCI : timer_reset_value;
        end
        else
        begin
            if (pri_timer_we)
                primary_timer <= reg_wdata[PRI_TIMER_LSB +: BYTE_W];
            if (sec_timer_we)
                secondary_timer <= reg_wdata[SEC_TIMER_LSB +: BYTE_W];
        end
    end

    // ------------------------------------------------------------
    // bus numbers and I/O window
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            bus_numbers <= '{highest: BUS_RST, downstream: BUS_RST, upstream: BUS_RST};
            io_window   <= '{limit: IO_NIB_RST, base: IO_NIB_RST};
        end
        else
        begin
            // full dword write updates all three
            if (wr_bus)
            begin
                bus_numbers.upstream   <= reg_wdata[UPSTREAM_LSB +: BYTE_W];
                bus_numbers.downstream <= reg_wdata[DOWNSTREAM_LSB +: BYTE_W];
                bus_numbers.highest    <= reg_wdata[HIGHEST_LSB +: BYTE_W];
            end
            // base and limit nibbles writable, low bits fixed
            if (wr_io)
            begin
                io_window.base  <= reg_wdata[IO_BASE_LSB +: NIB_W];
                io_window.limit <= reg_wdata[IO_LIMIT_LSB +: NIB_W];
            end
        end
    end

    // ------------------------------------------------------------
    // read data assembly
    // ------------------------------------------------------------
    wire logic [BYTE_W-1:0] pri_timer_view;
    wire logic [BYTE_W-1:0] sec_timer_view;
    wire logic              cap_66;
    wire logic              cap_fbb;
    wire logic [DATA_W-1:0] dword_hdr;
    wire logic [DATA_W-1:0] dword_bus;
    wire logic [DATA_W-1:0] dword_io;
    wire logic [DATA_W-1:0] read_mux;

    assign pri_timer_view = reverse_mode ? primary_timer : TIMER_RST_PCI;
    assign sec_timer_view = reverse_mode ? TIMER_RST_PCI : secondary_timer;
    // 66 MHz only in forward mode
    assign cap_66 = !reverse_mode;
    // forward fast back-to-back only on PCI
    assign cap_fbb = !reverse_mode && !pcix_mode;

    // single function bit fixed at zero
    // cache line size byte belongs to another block, reads zero here
    assign dword_hdr = {BYTE_W'(0), 1'b0, LAYOUT_BRIDGE, pri_timer_view, BYTE_W'(0)};

    assign dword_bus = {sec_timer_view, bus_numbers.highest,
                        bus_numbers.downstream, bus_numbers.upstream};

    // base capability bits and reserved zero
    // limit capability bits and reserved zero
    // upper status byte lives elsewhere, reads zero here
    assign dword_io = {BYTE_W'(0), cap_fbb, 1'b0, cap_66, 5'h00,
                       io_window.limit, 2'h0, IO_ADDR_32,
                       io_window.base, 2'h0, IO_ADDR_32};

    // reserved dwords and unmapped offsets read zero
    assign read_mux = hit_hdr ? dword_hdr :
                      hit_bus ? dword_bus :
                      hit_io  ? dword_io  : READ_ZERO;

    // data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys)
    begin
        if (srst || !reg_rd)
            reg_rdata <= READ_ZERO;
        else
            reg_rdata <= read_mux;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic past_valid;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            past_valid <= 1'b0;
        else
            past_valid <= 1'b1;
    end

    property p_pri_timer_forward;
        @(posedge clk_sys) disable iff (srst)
        (past_valid && reg_rd && hit_hdr && !reverse_mode)
            |=> (reg_rdata[PRI_TIMER_LSB +: BYTE_W] == TIMER_RST_PCI);
    endproperty
    a_pri_timer_forward: assert property (p_pri_timer_forward)
        else $error("primary timer not zero in forward mode");

    property p_timer_reset;
        @(posedge clk_sys)
        $fell(srst) |->
            ((reverse_mode ? primary_timer : secondary_timer)
                == (pcix_mode ? TIMER_RST_PCIX : TIMER_RST_PCI))
            && ((reverse_mode ? secondary_timer : primary_timer) == TIMER_RST_PCI);
    endproperty
    a_timer_reset: assert property (p_timer_reset)
        else $error("writable timer reset value wrong");

    property p_sec_timer_write;
        @(posedge clk_sys) disable iff (srst)
        (past_valid && reg_wr && hit_bus && !reverse_mode)
            |=> (secondary_timer == $past(reg_wdata[SEC_TIMER_LSB +: BYTE_W]));
    endproperty
    a_sec_timer_write: assert property (p_sec_timer_write)
        else $error("secondary timer write lost in forward mode");

    property p_sec_timer_reverse;
        @(posedge clk_sys) disable iff (srst)
        (reg_rd && hit_bus && reverse_mode)
            |=> (reg_rdata[SEC_TIMER_LSB +: BYTE_W] == TIMER_RST_PCI);
    endproperty
    a_sec_timer_reverse: assert property (p_sec_timer_reverse)
        else $error("secondary timer not zero in reverse mode");

    property p_layout;
        @(posedge clk_sys) disable iff (srst)
        (reg_rd && hit_hdr)
            |=> (reg_rdata[LAYOUT_LSB +: $bits(LAYOUT_BRIDGE)] == LAYOUT_BRIDGE);
    endproperty
    a_layout: assert property (p_layout)
        else $error("header layout code wrong");

    property p_single_fn;
        @(posedge clk_sys) disable iff (srst)
        (reg_rd && hit_hdr) |=> !reg_rdata[MULTI_FN_BIT];
    endproperty
    a_single_fn: assert property (p_single_fn)
        else $error("multi function bit set");

    property p_bus_write;
        @(posedge clk_sys) disable iff (srst)
        (reg_wr && hit_bus) ##1 (reg_rd && hit_bus)
            |=> (reg_rdata[HIGHEST_LSB +: BYTE_W] == $past(reg_wdata[HIGHEST_LSB +: BYTE_W], 2))
             && (reg_rdata[UPSTREAM_LSB +: BYTE_W] == bus_numbers.upstream);
    endproperty
    a_bus_write: assert property (p_bus_write)
        else $error("bus number write not read back");

    property p_io_base_fixed;
        @(posedge clk_sys) disable iff (srst)
        (reg_rd && hit_io) |=> (reg_rdata[IO_BASE_CAP +: NIB_W] == {2'h0, IO_ADDR_32});
    endproperty
    a_io_base_fixed: assert property (p_io_base_fixed)
        else $error("I/O base low bits wrong");

    property p_io_base_write;
        @(posedge clk_sys) disable iff (srst)
        (past_valid && reg_wr && hit_io)
            |=> (io_window.base == $past(reg_wdata[IO_BASE_LSB +: NIB_W]));
    endproperty
    a_io_base_write: assert property (p_io_base_write)
        else $error("I/O base nibble write lost");

    property p_io_limit;
        @(posedge clk_sys) disable iff (srst)
        (reg_rd && hit_io)
            |=> (reg_rdata[IO_LIMIT_CAP +: NIB_W] == {2'h0, IO_ADDR_32})
             && (reg_rdata[IO_LIMIT_LSB +: NIB_W] == io_window.limit);
    endproperty
    a_io_limit: assert property (p_io_limit)
        else $error("I/O limit byte wrong");

    property p_cap_66;
        @(posedge clk_sys) disable iff (srst)
        (reg_rd && hit_io) |=> (reg_rdata[CAP_66_BIT] == !reverse_mode);
    endproperty
    a_cap_66: assert property (p_cap_66)
        else $error("66 MHz capable bit wrong");

    property p_fbb_forward;
        @(posedge clk_sys) disable iff (srst)
        (reg_rd && hit_io && !reverse_mode)
            |=> (reg_rdata[FBB_CAP_BIT] == !pcix_mode);
    endproperty
    a_fbb_forward: assert property (p_fbb_forward)
        else $error("forward fast back-to-back bit wrong");

    property p_fbb_reverse;
        @(posedge clk_sys) disable iff (srst)
        (reg_rd && hit_io && reverse_mode) |=> !reg_rdata[FBB_CAP_BIT];
    endproperty
    a_fbb_reverse: assert property (p_fbb_reverse)
        else $error("reverse fast back-to-back bit set");

    property p_reserved_ignored;
        @(posedge clk_sys) disable iff (srst)
        (past_valid && reg_wr && !hit_bus && !hit_io && !(hit_hdr && reverse_mode))
            |=> $stable(bus_numbers) && $stable(io_window)
             && $stable(primary_timer) && $stable(secondary_timer);
    endproperty
    a_reserved_ignored: assert property (p_reserved_ignored)
        else $error("write to fixed field changed state");

    property p_pri_ro_ignored;
        @(posedge clk_sys) disable iff (srst)
        (past_valid && reg_wr && hit_hdr && !reverse_mode) |=> $stable(primary_timer);
    endproperty
    a_pri_ro_ignored: assert property (p_pri_ro_ignored)
        else $error("read-only primary timer changed");

    property p_pri_timer_write;
        @(posedge clk_sys) disable iff (srst)
        (past_valid && reg_wr && hit_hdr && reverse_mode)
            |=> (primary_timer == $past(reg_wdata[PRI_TIMER_LSB +: BYTE_W]));
    endproperty
    a_pri_timer_write: assert property (p_pri_timer_write)
        else $error("primary timer write lost in reverse mode");

    property p_sec_ro_ignored;
        @(posedge clk_sys) disable iff (srst)
        (past_valid && reg_wr && hit_bus && reverse_mode) |=> $stable(secondary_timer);
    endproperty
    a_sec_ro_ignored: assert property (p_sec_ro_ignored)
        else $error("read-only secondary timer changed");

    property p_io_limit_write;
        @(posedge clk_sys) disable iff (srst)
        (past_valid && reg_wr && hit_io)
            |=> (io_window.limit == $past(reg_wdata[IO_LIMIT_LSB +: NIB_W]));
    endproperty
    a_io_limit_write: assert property (p_io_limit_write)
        else $error("I/O limit nibble write lost");

    property p_unmapped_read;
        @(posedge clk_sys) disable iff (srst)
        (reg_rd && !hit_hdr && !hit_bus && !hit_io) |=> (reg_rdata == READ_ZERO);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("reserved or unmapped offset read not zero");

    property p_rdata_idle;
        @(posedge clk_sys) disable iff (srst)
        !reg_rd |=> (reg_rdata == READ_ZERO);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data present without read strobe");

endmodule : bridge_cfg_header_0c_to_1c

// >>> verilog/bridge_cfg_pkg.sv
package bridge_cfg_pkg;

    // ------------------------------------------------------------
    // bus widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BYTE_W = 8;
    localparam int NIB_W  = 4;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_HDR  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_RSV0 = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_RSV1 = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_BUS  = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_IO   = 8'h1C;

    // ------------------------------------------------------------
    // field positions (lsb)
    // ------------------------------------------------------------
    localparam int PRI_TIMER_LSB  = 8;
    localparam int LAYOUT_LSB     = 16;
    localparam int MULTI_FN_BIT   = 23;
    localparam int UPSTREAM_LSB   = 0;
    localparam int DOWNSTREAM_LSB = 8;
    localparam int HIGHEST_LSB    = 16;
    localparam int SEC_TIMER_LSB  = 24;
    localparam int IO_BASE_CAP    = 0;
    localparam int IO_BASE_LSB    = 4;
    localparam int IO_LIMIT_CAP   = 8;
    localparam int IO_LIMIT_LSB   = 12;
    localparam int CAP_66_BIT     = 21;
    localparam int FBB_CAP_BIT    = 23;

    // ------------------------------------------------------------
    // fixed and reset values
    // ------------------------------------------------------------
    localparam logic [6:0]        LAYOUT_BRIDGE   = 7'h01;
    localparam logic [1:0]        IO_ADDR_32      = 2'h1;
    localparam logic [BYTE_W-1:0] TIMER_RST_PCI   = 8'h00;
    localparam logic [BYTE_W-1:0] TIMER_RST_PCIX  = 8'h40;
    localparam logic [BYTE_W-1:0] BUS_RST         = 8'h00;
    localparam logic [NIB_W-1:0]  IO_NIB_RST      = 4'h0;
    localparam logic [DATA_W-1:0] READ_ZERO       = 32'h0000_0000;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [BYTE_W-1:0] highest;
        logic [BYTE_W-1:0] downstream;
        logic [BYTE_W-1:0] upstream;
    } bus_numbers_type;

    typedef struct packed {
        logic [NIB_W-1:0] limit;
        logic [NIB_W-1:0] base;
    } io_window_type;

endpackage : bridge_cfg_pkg
